//--- hdl/ssic_map.svh
// Named widths, reset values and counts of the SRAM input control block.
`ifndef SSIC_MAP_SVH
`define SSIC_MAP_SVH
`define SSIC_ADDR_W 21
`define SSIC_ADDR_HI 20
`define SSIC_LANES 4
`define SSIC_BCNT_W 2
`define SSIC_BCNT_HI 1
`define SSIC_UPPER_LO 2
`define SSIC_CNT_RST 2'h0
`define SSIC_CNT_STEP 2'h1
`define SSIC_ADDR_RST 21'h000000
`define SSIC_LANE_RST 4'h0
`define SSIC_ORDER_RST 1'h1
`define SSIC_SEEN_RST 1'h0
`endif

//--- hdl/ssic_pkg.sv
// Types shared by the SRAM input control block.
package ssic_pkg;
   typedef enum logic [1:0] {
      SSIC_OP_IDLE  = 2'b00,
      SSIC_OP_READ  = 2'b01,
      SSIC_OP_WRITE = 2'b10
   } ssic_op_t;
endpackage

//--- hdl/ssic_burst_seq.sv
// Burst offset generator for linear and interleaved orders.
`timescale 1ns/1ns
`include "ssic_map.svh"
module ssic_burst_seq
   import ssic_pkg::*;
(
   // Burst inputs
   input wire logic [`SSIC_BCNT_HI:0] start,
   input wire logic [`SSIC_BCNT_HI:0] count,
   input wire logic interleave,
   // Result
   output logic [`SSIC_BCNT_HI:0] offset
);
   // =========================================================
   // Offset
   always_comb begin
      if (interleave) begin
         offset = start ^ count;
      end else begin
         offset = start + count;
      end
   end
endmodule

//--- hdl/ssic_input_ctrl.sv
// Synchronous control input front end of a flow-through burst SRAM.
//
// Contract
// - Address inputs taken on a qualified rising edge select the location.
// - The two low address bits load the two-bit burst start; the burst counter clears to zero.
// - A low lane strobe writes its lane only in a write that write enable low started on a load.
// - Write enable low starts a write and is sampled only while qualified.
// - Advance high on a qualified edge steps the burst counter during a read or write burst.
// - Advance low takes a new address and reloads the burst counter.
// - Edges with the clock qualifier high are ignored, except that the strap is still caught at the first edge after reset.
// - Selection needs select one low, select two high, select three low.
// - Qualifier high freezes state and does not deselect the device.
// - The burst order is linear with the strap low, else interleaved.
`timescale 1ns/1ns
`include "ssic_map.svh"
module ssic_input_ctrl
   import ssic_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Access control inputs
   input wire logic [`SSIC_ADDR_HI:0] addr,
   input wire logic [`SSIC_LANES-1:0] byte_lane_write_strobe_n,
   input wire logic write_en_n,
   input wire logic advance_or_load,
   input wire logic clock_qualify_n,
   // Chip selects
   input wire logic chip_select_one_n,
   input wire logic chip_select_two,
   input wire logic chip_select_three_n,
   // Burst order strap
   input wire logic burst_order_strap,
   // Access outputs
   output logic [`SSIC_ADDR_HI:0] access_addr_q,
   output ssic_op_t op_q,
   output logic [`SSIC_LANES-1:0] lane_write_en_q,
   output logic [`SSIC_BCNT_HI:0] burst_start_q,
   output logic [`SSIC_BCNT_HI:0] burst_count_q,
   output logic interleave_q
);
   // =========================================================
   // Declarations
   logic [`SSIC_ADDR_HI:0] access_addr_d;
   ssic_op_t op_d;
   logic [`SSIC_LANES-1:0] lane_write_en_d;
   logic [`SSIC_LANES-1:0] lane_req;
   logic [`SSIC_BCNT_HI:0] burst_start_d;
   logic [`SSIC_BCNT_HI:0] burst_count_d;
   logic [`SSIC_BCNT_HI:0] step_count;
   logic [`SSIC_BCNT_HI:0] step_offset;
   logic interleave_d;
   logic strap_seen_q;
   logic strap_seen_d;
   logic qualified;
   logic selected;
   logic bursting;
   logic do_write;

   assign qualified = ~clock_qualify_n;
   assign selected = ~chip_select_one_n & chip_select_two &
                     ~chip_select_three_n;
   assign bursting = (op_q != SSIC_OP_IDLE);
   assign step_count = burst_count_q + `SSIC_CNT_STEP;

   // =========================================================
   // Lane strobes
   always_comb begin
      if (advance_or_load) begin
         do_write = (op_q == SSIC_OP_WRITE);
      end else begin
         do_write = selected & ~write_en_n;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `SSIC_LANES; gi = gi + 1) begin : g_lane
         assign lane_req[gi] = do_write &
                               ~byte_lane_write_strobe_n[gi];
      end
   endgenerate

   // =========================================================
   // Burst sequence
   ssic_burst_seq u_seq (
      .start(burst_start_q),
      .count(step_count),
      .interleave(interleave_q),
      .offset(step_offset)
   );

   // =========================================================
   // Burst order strap
   // The strap is caught at the first edge after reset release.
   always_comb begin
      strap_seen_d = 1'b1;
      interleave_d = interleave_q;
      if (!strap_seen_q) begin
         interleave_d = burst_order_strap;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         strap_seen_q <= `SSIC_SEEN_RST;
         interleave_q <= `SSIC_ORDER_RST;
      end else begin
         strap_seen_q <= strap_seen_d;
         interleave_q <= interleave_d;
      end
   end

   // =========================================================
   // Access state
   always_comb begin
      access_addr_d = access_addr_q;
      op_d = op_q;
      lane_write_en_d = lane_write_en_q;
      burst_start_d = burst_start_q;
      burst_count_d = burst_count_q;
      if (qualified) begin
         if (!advance_or_load) begin
            burst_count_d = `SSIC_CNT_RST;
            lane_write_en_d = lane_req;
            if (selected) begin
               access_addr_d = addr;
               burst_start_d = addr[`SSIC_BCNT_HI:0];
               op_d = write_en_n ? SSIC_OP_READ : SSIC_OP_WRITE;
            end else begin
               op_d = SSIC_OP_IDLE;
            end
         end else begin
            case (op_q)
               SSIC_OP_READ, SSIC_OP_WRITE: begin
                  burst_count_d = step_count;
                  access_addr_d = {access_addr_q[`SSIC_ADDR_HI:`SSIC_UPPER_LO],
                                   step_offset};
                  lane_write_en_d = lane_req;
               end
               default: begin
                  // Advance while deselected keeps the device idle.
                  op_d = SSIC_OP_IDLE;
                  lane_write_en_d = `SSIC_LANE_RST;
               end
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         access_addr_q <= `SSIC_ADDR_RST;
         op_q <= SSIC_OP_IDLE;
         lane_write_en_q <= `SSIC_LANE_RST;
         burst_start_q <= `SSIC_CNT_RST;
         burst_count_q <= `SSIC_CNT_RST;
      end else begin
         access_addr_q <= access_addr_d;
         op_q <= op_d;
         lane_write_en_q <= lane_write_en_d;
         burst_start_q <= burst_start_d;
         burst_count_q <= burst_count_d;
      end
   end

   // =========================================================
   // Assertions
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   logic load_sel;
   assign load_sel = qualified & ~advance_or_load & selected;

   a_load_addr_capture: assert property (
      load_sel |=> access_addr_q == $past(addr))
      else $error("Loaded address not captured.");

   a_load_counter_bits: assert property (
      load_sel |=> burst_start_q == $past(addr[`SSIC_BCNT_HI:0]))
      else $error("Burst start not taken from low address bits.");

   a_lane_needs_write: assert property (
      (lane_write_en_q != `SSIC_LANE_RST) |-> op_q == SSIC_OP_WRITE)
      else $error("Lane write enabled without a write.");

   a_write_start: assert property (
      load_sel && !write_en_n |=> op_q == SSIC_OP_WRITE &&
         lane_write_en_q == ~$past(byte_lane_write_strobe_n))
      else $error("Write not started on write enable low.");

   a_advance_step: assert property (
      qualified && advance_or_load && bursting |=>
         burst_count_q == $past(burst_count_q) + `SSIC_CNT_STEP)
      else $error("Burst counter did not step.");

   a_load_reload: assert property (
      qualified && !advance_or_load |=> burst_count_q == `SSIC_CNT_RST)
      else $error("Burst counter not reloaded.");

   a_suspend_freeze: assert property (
      !qualified |=> $stable(access_addr_q) && $stable(op_q) &&
         $stable(lane_write_en_q) && $stable(burst_count_q))
      else $error("State changed on an unqualified edge.");

   a_suspend_keeps: assert property (
      bursting ##1 !qualified [*3] |=> op_q == $past(op_q, 3))
      else $error("Suspend changed the selection.");

   a_select_decode: assert property (
      qualified && !advance_or_load && !selected |=> op_q == SSIC_OP_IDLE)
      else $error("Device selected with chip selects inactive.");

   a_order_linear: assert property (
      bursting && !interleave_q |-> access_addr_q[`SSIC_BCNT_HI:0] ==
         burst_start_q + burst_count_q)
      else $error("Linear burst order broken.");

   a_order_interleave: assert property (
      bursting && interleave_q |-> access_addr_q[`SSIC_BCNT_HI:0] ==
         (burst_start_q ^ burst_count_q))
      else $error("Interleaved burst order broken.");

   a_upper_fixed: assert property (
      qualified && advance_or_load && bursting |=>
         access_addr_q[`SSIC_ADDR_HI:`SSIC_UPPER_LO] ==
         $past(access_addr_q[`SSIC_ADDR_HI:`SSIC_UPPER_LO]))
      else $error("Upper address bits changed in a burst.");

   c_write_burst: cover property (
      load_sel && !write_en_n ##1 qualified && advance_or_load [*3]);
   c_read_burst: cover property (
      load_sel && write_en_n ##1 qualified && advance_or_load [*3]);
   c_suspend: cover property (bursting ##1 !qualified [*2] ##1 qualified);
   c_deselect: cover property (
      bursting ##1 qualified && !advance_or_load && !selected);
endmodule

//--- sim/ssic_host.sv
// Host controller model driving the SRAM control inputs.
`timescale 1ns/1ns
module ssic_host (
   // Clock
   input wire logic ref_clk,
   // Control outputs, selects as one low, two, three low
   output logic [20:0] addr,
   output logic [3:0] str_n,
   output logic we_n,
   output logic adv,
   output logic cq_n,
   output logic [2:0] cs
);
   initial begin
      addr = 21'h000000;
      str_n = 4'hF;
      we_n = 1'b1;
      adv = 1'b0;
      cq_n = 1'b1;
      cs = 3'h5;
   end
   // Present one qualified request, taken at the next rising edge.
   task automatic op(input logic l, input logic [20:0] a, input logic w,
      input logic [3:0] s, input logic [2:0] c);
      @(posedge ref_clk);
      #1;
      cq_n = 1'b0;
      adv = l;
      addr = a;
      we_n = w;
      str_n = s;
      cs = c;
   endtask
   // Unqualified cycle: every other line turns over so stale values show.
   task automatic idle();
      @(posedge ref_clk);
      #1;
      cq_n = 1'b1;
      addr = ~addr;
      adv = ~adv;
      we_n = ~we_n;
      cs = ~cs;
      str_n = ~str_n;
   endtask
endmodule

//--- sim/tb.sv
// Self-checking bench of the SRAM input control block.
`timescale 1ns/1ns
module tb
   import ssic_pkg::*;
;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic strap = 1'b0;
   logic [20:0] addr, acc;
   logic [3:0] str_n, lanes;
   logic [2:0] cs;
   logic we_n, adv, cq_n, ilv;
   logic [1:0] bst, bcnt;
   ssic_op_t op;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         num_errors++;
         end_sim();
      end
   end
   ssic_host h (.ref_clk(ref_clk), .addr(addr), .str_n(str_n),
      .we_n(we_n), .adv(adv), .cq_n(cq_n), .cs(cs));
   ssic_input_ctrl dut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr),
      .byte_lane_write_strobe_n(str_n), .write_en_n(we_n),
      .advance_or_load(adv), .clock_qualify_n(cq_n),
      .chip_select_one_n(cs[2]), .chip_select_two(cs[1]),
      .chip_select_three_n(cs[0]), .burst_order_strap(strap),
      .access_addr_q(acc), .op_q(op), .lane_write_en_q(lanes),
      .burst_start_q(bst), .burst_count_q(bcnt), .interleave_q(ilv));
   // ==========================================================
   // Comparison and closing.
   task automatic chk(input string n, input logic [20:0] e,
      input logic [20:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic outs(input logic [20:0] a, input ssic_op_t o,
      input logic [3:0] l, input logic [1:0] s, input logic [1:0] c);
      chk("addr", a, acc);
      chk("op", o, op);
      chk("lanes", l, lanes);
      chk("start", s, bst);
      chk("count", c, bcnt);
   endtask
   task automatic end_sim();
      $display("errors %0d of %0d checks", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios.
   task automatic rst(input logic s);
      nrst = 1'b0;
      strap = s;
      repeat (16) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      h.idle();
      outs(21'h000000, SSIC_OP_IDLE, 4'h0, 2'h0, 2'h0);
      chk("ilv", s, ilv);
   endtask
   task automatic t_wr_burst();
      h.op(1'b0, 21'h1ABCDE, 1'b0, 4'hA, 3'h2);
      h.op(1'b1, 21'h000000, 1'b1, 4'h3, 3'h5);
      outs(21'h1ABCDE, SSIC_OP_WRITE, 4'h5, 2'h2, 2'h0);
      h.op(1'b1, 21'h000000, 1'b1, 4'h0, 3'h2);
      outs(21'h1ABCDF, SSIC_OP_WRITE, 4'hC, 2'h2, 2'h1);
      h.idle();
      outs(21'h1ABCDC, SSIC_OP_WRITE, 4'hF, 2'h2, 2'h2);
      h.idle();
      outs(21'h1ABCDC, SSIC_OP_WRITE, 4'hF, 2'h2, 2'h2);
      h.idle();
      outs(21'h1ABCDC, SSIC_OP_WRITE, 4'hF, 2'h2, 2'h2);
   endtask
   task automatic t_desel();
      for (int i = 0; i < 3; i++) begin
         h.op(1'b0, 21'h0F0F0F, 1'b0, 4'h0, 3'h2 ^ (3'h4 >> i));
         h.op(1'b1, 21'h000000, 1'b0, 4'h0, 3'h2);
         chk("op", SSIC_OP_IDLE, op);
         chk("lanes", 4'h0, lanes);
         h.idle();
         chk("op", SSIC_OP_IDLE, op);
      end
      h.op(1'b0, 21'h0F0F0F, 1'b1, 4'h0, 3'h2);
      h.op(1'b1, 21'h000000, 1'b0, 4'h0, 3'h5);
      outs(21'h0F0F0F, SSIC_OP_READ, 4'h0, 2'h3, 2'h0);
      h.op(1'b1, 21'h000000, 1'b0, 4'h0, 3'h5);
      h.op(1'b1, 21'h000000, 1'b0, 4'h0, 3'h5);
      h.idle();
      outs(21'h0F0F0E, SSIC_OP_READ, 4'h0, 2'h3, 2'h3);
   endtask
   task automatic t_ilv();
      h.op(1'b0, 21'h155551, 1'b0, 4'hF, 3'h2);
      h.op(1'b1, 21'h000000, 1'b0, 4'h0, 3'h2);
      h.op(1'b1, 21'h000000, 1'b0, 4'h7, 3'h2);
      outs(21'h155550, SSIC_OP_WRITE, 4'hF, 2'h1, 2'h1);
      h.idle();
      outs(21'h155553, SSIC_OP_WRITE, 4'h8, 2'h1, 2'h2);
   endtask
   initial begin
      rst(1'b0);
      t_wr_burst();
      t_desel();
      rst(1'b1);
      t_ilv();
      end_sim();
   end
endmodule
